// ==== include/ret_stack_pkg.sv ====
// Constants for the four-entry return-address stack.
// Assumes a single processor clock; no software-visible registers.
package ret_stack_pkg;
    localparam int unsigned DEPTH      = 4;
    localparam int unsigned ADDR_W     = 16;
    localparam int unsigned REG_W      = 56;
    localparam int unsigned FIELD_LO   = 12;
    localparam int unsigned FIELD_HI   = 27;
    localparam logic [15:0] ENTRY_ZERO = 16'h0000;
    localparam logic [2:0]  COUNT_ZERO = 3'h0;
    localparam logic [2:0]  COUNT_FULL = 3'h4;
    localparam logic [2:0]  COUNT_ONE  = 3'h1;
endpackage

// ==== logic/return_address_stack.sv ====
// Four-entry return-address stack for the processor sequencer.
// Assumes the sequencer may raise more than one operation strobe per cycle; a push beats a pop and a call beats a lift.
`timescale 1ns/1ps

module return_address_stack (
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    // Operation strobes from the sequencer
    input  wire logic                              call_i,
    input  wire logic                              subroutine_return_i,
    input  wire logic                              discard_return_entry_i,
    input  wire logic                              stack_to_register_i,
    input  wire logic                              register_to_stack_i,
    // Operands
    input  wire logic [ret_stack_pkg::ADDR_W-1:0]  call_addr_i,
    input  wire logic [ret_stack_pkg::REG_W-1:0]   c_reg_i,
    // Results
    output logic                                   pc_load_o,
    output logic [ret_stack_pkg::ADDR_W-1:0]       program_counter_o,
    output logic                                   c_load_o,
    output logic [ret_stack_pkg::ADDR_W-1:0]       c_field_o,
    output logic [ret_stack_pkg::ADDR_W-1:0]       bottom_o,
    output logic [2:0]                             depth_o
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [ret_stack_pkg::DEPTH-1:0][ret_stack_pkg::ADDR_W-1:0] entry;
        logic [2:0]                                                 count;
        logic                                                       pc_load;
        logic [ret_stack_pkg::ADDR_W-1:0]                           pc;
        logic                                                       c_load;
        logic [ret_stack_pkg::ADDR_W-1:0]                           c_field;
    } state_s;

    state_s state_q;
    state_s state_d;

    logic push;
    logic pop;
    logic [ret_stack_pkg::ADDR_W-1:0] push_val;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        push     = call_i | register_to_stack_i;
        pop      = subroutine_return_i | discard_return_entry_i | stack_to_register_i;
        push_val = call_i ? call_addr_i : c_reg_i[ret_stack_pkg::FIELD_HI:ret_stack_pkg::FIELD_LO];
        state_d         = state_q;
        state_d.pc_load = 1'b0;
        state_d.c_load  = 1'b0;
        if (push) begin
            // Oldest entry falls off the top; no overflow flag by design
            for (int i = ret_stack_pkg::DEPTH-1; i > 0; i--) begin
                state_d.entry[i] = state_q.entry[i-1];
            end
            state_d.entry[0] = push_val;
            if (state_q.count != ret_stack_pkg::COUNT_FULL) begin
                state_d.count = state_q.count + ret_stack_pkg::COUNT_ONE;
            end
        end else if (pop) begin
            // An empty pop shifts in zeros and leaves the depth at zero
            for (int i = 0; i < ret_stack_pkg::DEPTH-1; i++) begin
                state_d.entry[i] = state_q.entry[i+1];
            end
            state_d.entry[ret_stack_pkg::DEPTH-1] = ret_stack_pkg::ENTRY_ZERO;
            if (state_q.count != ret_stack_pkg::COUNT_ZERO) begin
                state_d.count = state_q.count - ret_stack_pkg::COUNT_ONE;
            end
            if (subroutine_return_i) begin
                state_d.pc_load = 1'b1;
                state_d.pc      = state_q.entry[0];
            end
            if (stack_to_register_i) begin
                state_d.c_load  = 1'b1;
                state_d.c_field = state_q.entry[0];
            end
        end
    end

    // Pulses clear with the entries so no stale return fires after reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign pc_load_o         = state_q.pc_load;
    assign program_counter_o = state_q.pc;
    assign c_load_o          = state_q.c_load;
    assign c_field_o         = state_q.c_field;
    assign bottom_o          = state_q.entry[0];
    assign depth_o           = state_q.count;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Free slots must read zero: a pop fills the top with zero and a push only
    // moves zeros upward, so a live value there means a shift went astray.
    logic free_zero;

    always_comb begin
        free_zero = 1'b1;
        for (int i = 0; i < ret_stack_pkg::DEPTH; i++) begin
            if ((i >= int'(depth_o)) && (state_q.entry[i] != ret_stack_pkg::ENTRY_ZERO)) begin
                free_zero = 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Push checks
    // ----------------------------------------
    call_push_a: assert property (call_i |=> bottom_o == $past(call_addr_i))
        else $error("call did not push address");
    push_shift_a: assert property (push |=> state_q.entry[3] == $past(state_q.entry[2]))
        else $error("push did not shift up");
    push_low_a: assert property (push |=> state_q.entry[1] == $past(state_q.entry[0]))
        else $error("push did not lift bottom");
    push_mid_a: assert property (push |=> state_q.entry[2] == $past(state_q.entry[1]))
        else $error("push did not lift middle");
    lift_low_a: assert property (register_to_stack_i |=> state_q.entry[1] == $past(state_q.entry[0]))
        else $error("lift did not move bottom up");
    depth_inc_a: assert property (push && (depth_o != ret_stack_pkg::COUNT_FULL)
        |=> depth_o == $past(depth_o) + ret_stack_pkg::COUNT_ONE)
        else $error("push did not count up");
    full_hold_a: assert property (push && (depth_o == ret_stack_pkg::COUNT_FULL)
        |=> depth_o == ret_stack_pkg::COUNT_FULL)
        else $error("full push changed depth");
    r2s_load_a: assert property (register_to_stack_i && !call_i
        |=> bottom_o == $past(c_reg_i[ret_stack_pkg::FIELD_HI:ret_stack_pkg::FIELD_LO]))
        else $error("C digits not pushed");
    lift_full_a: assert property (register_to_stack_i && !call_i && (depth_o == ret_stack_pkg::COUNT_FULL)
        |=> (depth_o == ret_stack_pkg::COUNT_FULL) && (state_q.entry[3] == $past(state_q.entry[2])))
        else $error("full lift did not drop top");
    // A push that meets a pop wins; the pop is ignored
    push_wins_a: assert property (push && pop
        |=> !pc_load_o && !c_load_o && (bottom_o == $past(push_val)))
        else $error("pop acted beside a push");

    // ----------------------------------------
    // Pop checks
    // ----------------------------------------
    ret_pc_a: assert property (subroutine_return_i && !push
        |=> pc_load_o && program_counter_o == $past(bottom_o))
        else $error("return did not load counter");
    ret_zero_a: assert property (pop && !push |=> state_q.entry[3] == ret_stack_pkg::ENTRY_ZERO)
        else $error("top not zeroed");
    discard_nopc_a: assert property (discard_return_entry_i && !push && !subroutine_return_i |=> !pc_load_o)
        else $error("discard touched counter");
    discard_noc_a: assert property (discard_return_entry_i && !push && !stack_to_register_i
        |=> !c_load_o)
        else $error("discard touched C digits");
    pop_drop_a: assert property (pop && !push |=> bottom_o == $past(state_q.entry[1]))
        else $error("pop did not drop");
    pop_mid_a: assert property (pop && !push
        |=> (state_q.entry[1] == $past(state_q.entry[2])) && (state_q.entry[2] == $past(state_q.entry[3])))
        else $error("pop did not shift down");
    s2r_copy_a: assert property (stack_to_register_i && !push |=> c_load_o && c_field_o == $past(bottom_o))
        else $error("copy to C wrong");
    copy_nopc_a: assert property (stack_to_register_i && !push && !subroutine_return_i |=> !pc_load_o)
        else $error("copy touched counter");
    depth_dec_a: assert property (pop && !push && (depth_o != ret_stack_pkg::COUNT_ZERO)
        |=> depth_o == $past(depth_o) - ret_stack_pkg::COUNT_ONE)
        else $error("pop did not count down");
    empty_pop_a: assert property (pop && !push && (depth_o == ret_stack_pkg::COUNT_ZERO)
        |=> (depth_o == ret_stack_pkg::COUNT_ZERO) && (bottom_o == ret_stack_pkg::ENTRY_ZERO))
        else $error("empty pop not zero");

    // ----------------------------------------
    // Output checks
    // ----------------------------------------
    // Held outputs move only on their own operation; the sequencer may read them late
    pc_hold_a: assert property (!(subroutine_return_i && !push)
        |=> $stable(program_counter_o))
        else $error("counter moved without a return");
    pc_quiet_a: assert property (!(subroutine_return_i && !push)
        |=> !pc_load_o)
        else $error("counter load without a return");
    c_hold_a: assert property (!(stack_to_register_i && !push)
        |=> $stable(c_field_o))
        else $error("C digits moved without a copy");
    c_quiet_a: assert property (!(stack_to_register_i && !push)
        |=> !c_load_o)
        else $error("C load without a copy");
    depth_cap_a: assert property (depth_o <= ret_stack_pkg::COUNT_FULL)
        else $error("depth exceeds four");
    free_zero_a: assert property (free_zero)
        else $error("free slot not zero");
    idle_hold_a: assert property (!push && !pop
        |=> $stable(state_q.entry) && $stable(depth_o))
        else $error("stack moved while idle");

    // ----------------------------------------
    // Reset check
    // ----------------------------------------
    // Own disable so that it stays live while reset is held
    reset_clear_a: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |-> (depth_o == ret_stack_pkg::COUNT_ZERO) && (bottom_o == ret_stack_pkg::ENTRY_ZERO)
        && !pc_load_o && !c_load_o && (program_counter_o == ret_stack_pkg::ENTRY_ZERO)
        && (c_field_o == ret_stack_pkg::ENTRY_ZERO))
        else $error("reset left state behind");

    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    full_push_c: cover property (depth_o == ret_stack_pkg::COUNT_FULL ##1 call_i);
    ret_c:       cover property (call_i ##1 subroutine_return_i);
    s2r_c:       cover property (register_to_stack_i ##1 stack_to_register_i);
    discard_c:   cover property (call_i ##1 discard_return_entry_i);
    push_pop_c:  cover property (push && pop);

endmodule

// ==== test/return_address_stack_tb.sv ====
// Bench for the return-address stack, driven through the sequencer model.
// Assumes outputs settle one edge after the request is taken.
`timescale 1ns/1ps
module return_address_stack_tb;
    logic clk_i, rst_i, pc_load_o, c_load_o;
    logic [4:0] op;
    logic [15:0] addr, program_counter_o, c_field_o, bottom_o;
    logic [55:0] creg;
    logic [2:0] depth_o;
    logic [15:0] exp_q [5] = '{16'hcafe, 16'h2002, 16'h2001, 16'hbeef, 16'h0};
    int n_fail = 0;
    int n_checks = 0;
    seq_model u_seq (.clk_i(clk_i), .op_o(op), .addr_o(addr), .creg_o(creg));
    return_address_stack dut (.clk_i(clk_i), .rst_i(rst_i), .call_i(op[0]), .subroutine_return_i(op[1]),
        .discard_return_entry_i(op[2]), .stack_to_register_i(op[3]), .register_to_stack_i(op[4]),
        .call_addr_i(addr), .c_reg_i(creg), .pc_load_o(pc_load_o), .program_counter_o(program_counter_o),
        .c_load_o(c_load_o), .c_field_o(c_field_o), .bottom_o(bottom_o), .depth_o(depth_o));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_push_full;
        for (int i = 1; i <= 5; i++)
            u_seq.issue(5'h01, 16'h1000 + 16'(i), 56'h0);
        cmp("depth", 16'h4, {13'h0, depth_o});
        cmp("bottom", 16'h1005, bottom_o);
    endtask
    task automatic t_pop_kinds;
        u_seq.issue(5'h02, 16'h0, 56'h0);
        cmp("pc_load", 16'h1, {15'h0, pc_load_o});
        cmp("pc", 16'h1005, program_counter_o);
        u_seq.issue(5'h04, 16'h0, 56'h0);
        cmp("bottom", 16'h1003, bottom_o);
        cmp("pc_load", 16'h0, {15'h0, pc_load_o});
        cmp("pc", 16'h1005, program_counter_o);
        u_seq.issue(5'h08, 16'h0, 56'h0);
        cmp("c_load", 16'h1, {15'h0, c_load_o});
        cmp("c_field", 16'h1003, c_field_o);
        cmp("bottom", 16'h1002, bottom_o);
    endtask
    // Full lift must drop the oldest entry; the fifth return shows the zero fill
    task automatic t_lift_full;
        u_seq.issue(5'h10, 16'h0, 56'hbeef000);
        cmp("bottom", 16'hbeef, bottom_o);
        u_seq.issue(5'h01, 16'h2001, 56'h0);
        u_seq.issue(5'h01, 16'h2002, 56'h0);
        u_seq.issue(5'h10, 16'h0, 56'hfffcafefff);
        cmp("depth", 16'h4, {13'h0, depth_o});
        for (int i = 0; i < 5; i++) begin
            u_seq.issue(5'h02, 16'h0, 56'h0);
            cmp("pc", exp_q[i], program_counter_o);
        end
    endtask
    // Mid-run reset clears every entry and output; an empty pop then reads zero
    task automatic t_reset_mid;
        u_seq.issue(5'h01, 16'h3001, 56'h0);
        u_seq.issue(5'h01, 16'h3002, 56'h0);
        u_seq.issue(5'h08, 16'h0, 56'h0);
        cmp("c_field", 16'h3002, c_field_o);
        u_seq.issue(5'h02, 16'h0, 56'h0);
        cmp("pc", 16'h3001, program_counter_o);
        u_seq.issue(5'h01, 16'h3003, 56'h0);
        rst_i = 1'b1;
        @(negedge clk_i);
        cmp("depth", 16'h0, {13'h0, depth_o});
        cmp("bottom", 16'h0, bottom_o);
        cmp("pc", 16'h0, program_counter_o);
        cmp("c_field", 16'h0, c_field_o);
        rst_i = 1'b0;
        u_seq.issue(5'h02, 16'h0, 56'h0);
        cmp("pc_load", 16'h1, {15'h0, pc_load_o});
        cmp("depth", 16'h0, {13'h0, depth_o});
        cmp("bottom", 16'h0, bottom_o);
    endtask
    // Back-to-back requests and the refused pairs: push wins, call beats lift
    task automatic t_back_to_back;
        u_seq.issue2(5'h01, 16'h4001, 56'h0, 5'h02, 16'h0, 56'h0);
        cmp("pc", 16'h4001, program_counter_o);
        cmp("pc_load", 16'h1, {15'h0, pc_load_o});
        u_seq.issue2(5'h10, 16'h0, 56'h4abc000, 5'h08, 16'h0, 56'h0);
        cmp("c_field", 16'h4abc, c_field_o);
        cmp("c_load", 16'h1, {15'h0, c_load_o});
        u_seq.issue2(5'h01, 16'h4002, 56'h0, 5'h04, 16'h0, 56'h0);
        cmp("depth", 16'h0, {13'h0, depth_o});
        cmp("pc", 16'h4001, program_counter_o);
        u_seq.issue(5'h03, 16'h4003, 56'h0);
        cmp("bottom", 16'h4003, bottom_o);
        cmp("pc_load", 16'h0, {15'h0, pc_load_o});
        u_seq.issue(5'h11, 16'h4004, 56'h5555000);
        cmp("bottom", 16'h4004, bottom_o);
        cmp("depth", 16'h2, {13'h0, depth_o});
    endtask
    initial begin
        rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        cmp("depth", 16'h0, {13'h0, depth_o});
        t_push_full();
        t_pop_kinds();
        t_lift_full();
        t_reset_mid();
        t_back_to_back();
        end_of_test();
    end
endmodule

// ==== test/seq_model.sv ====
// Sequencer model: raises the requested operation strobes, one or more, for one cycle per request.
// Assumes one bench process calls issue at a time.
`timescale 1ns/1ps
module seq_model (
    // Clock
    input  wire logic        clk_i,
    // Strobes and operands
    output logic [4:0]       op_o,
    output logic [15:0]      addr_o,
    output logic [55:0]      creg_o
);
    initial begin
        op_o   = 5'h0;
        addr_o = 16'h0;
        creg_o = 56'h0;
    end
    // Operands invert when idle so stale values are never mistaken for live ones
    task automatic issue(input logic [4:0] op, input logic [15:0] a, input logic [55:0] c);
        @(negedge clk_i);
        op_o   = op;
        addr_o = a;
        creg_o = c;
        @(negedge clk_i);
        op_o   = 5'h0;
        addr_o = ~a;
        creg_o = ~c;
    endtask
    // Two requests on consecutive cycles, as the sequencer may issue them
    task automatic issue2(input logic [4:0] op1, input logic [15:0] a1, input logic [55:0] c1,
                          input logic [4:0] op2, input logic [15:0] a2, input logic [55:0] c2);
        @(negedge clk_i);
        op_o   = op1;
        addr_o = a1;
        creg_o = c1;
        @(negedge clk_i);
        op_o   = op2;
        addr_o = a2;
        creg_o = c2;
        @(negedge clk_i);
        op_o   = 5'h0;
        addr_o = ~a2;
        creg_o = ~c2;
    endtask
endmodule
